// ===== hw/esa_defines.svh
`ifndef ESA_DEFINES_SVH
`define ESA_DEFINES_SVH

// Register index as printed; byte address is four times the index
`define ESA_CTRL1_IDX        12'h131
`define ESA_CTRL1_ADDR       12'h4c4
`define ESA_STATUS_ADDR      12'h4c8
`define ESA_CTRL1_RESET      8'h00

// Enable bit positions in the control register
`define ESA_BIT_CL1          7
`define ESA_BIT_SL1          6
`define ESA_BIT_CL2          5
`define ESA_BIT_CL3          4
`define ESA_BIT_CL4          3
`define ESA_BIT_PWR          2
`define ESA_BIT_PWRLINE      1
`define ESA_BIT_SLAUX        0

// Sa6 patterns, sent MSB first, twice over one submultiframe
`define ESA_SA6_ZERO         4'h0
`define ESA_SA6_1110         4'he
`define ESA_SA6_1100         4'hc
`define ESA_SA6_1000         4'h8
`define ESA_AUX_PATTERN      8'haa
// Sa5 value used for the loss-of-power pattern (not legible in source)
`define ESA_PWR_SA5          1'b0

`endif

// ===== hw/esa_pkg.sv
package esa_pkg;

    // Overhead bits presented to the transmit framer for one frame
    typedef struct packed {
        logic a_bit;
        logic sa5;
        logic sa6;
    } esa_ovh_t;

    // Defect indications from the receive side
    typedef struct packed {
        logic signal_loss;
        logic frame_loss;
        logic power_loss;
    } esa_defect_t;

    typedef enum logic [3:0] {
        ESA_SEL_NONE    = 4'b0000,
        ESA_SEL_CL1     = 4'b0001,
        ESA_SEL_SL1     = 4'b0010,
        ESA_SEL_CL2     = 4'b0011,
        ESA_SEL_CL3     = 4'b0100,
        ESA_SEL_CL4     = 4'b0101,
        ESA_SEL_PWR     = 4'b0110,
        ESA_SEL_PWRLINE = 4'b0111,
        ESA_SEL_SLAUX   = 4'b1000
    } esa_sel_t;

endpackage

// ===== hw/esa_auto_alarm.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`include "esa_defines.svh"
// How it works
// [RQ1] Enable 7, LOS or LFA: Sa5=1, Sa6=0000
// [RQ2] Enable 6, LOS: A=1, Sa5=1, Sa6=1110
// [RQ3] Enable 5, LOS or LFA: A=1, Sa5=0, Sa6=0000
// [RQ4] Enable 4, LOS or LFA: A=0, Sa5=1, Sa6=1100
// [RQ5] Enable 3, LOS or LFA: A=0, Sa5=1, Sa6=1110
// [RQ6] Enable 0, LOS: Sa5/Sa6 carry 10101010
// [RQ7] Enable 2, power loss: A=0, Sa6=1000
// [RQ8] Enable 1, power+line loss: A=1, Sa5=0, Sa6=1000
// [RQ9] Pattern holds only while condition persists; the code keeps it until the next submultiframe start
// [RQ10] Highest bit wins; Sa6 nibble MSB first
module esa_auto_alarm
    import esa_pkg::*;
(
    input  wire logic        SYS_CLK,          // 100 MHz system clock
    input  wire logic        RST_N,            // Asynchronous reset, active low
    input  wire logic        PSEL,             // APB select
    input  wire logic        PENABLE,          // APB access phase
    input  wire logic        PWRITE,           // APB direction
    input  wire logic [11:0] PADDR,            // APB byte address
    input  wire logic [31:0] PWDATA,           // APB write data
    output logic      [31:0] PRDATA,           // APB read data
    output logic             PREADY,           // APB ready
    output logic             PSLVERR,          // APB error on unmapped address
    input  wire logic        SIGNAL_LOSS,      // Receive loss of signal, async
    input  wire logic        FRAME_LOSS,       // Receive loss of frame alignment, async
    input  wire logic        POWER_LOSS,       // Loss of power indication, async
    input  wire logic        FRAME_STROBE,     // One pulse per outgoing frame with Sa bits
    input  wire logic        SMF_START,        // With strobe: first frame of submultiframe
    input  wire esa_ovh_t    NORMAL_OVH,       // Normally selected A, Sa5, Sa6 bits
    output esa_ovh_t         TX_OVH,           // A, Sa5, Sa6 bits sent this frame
    output logic             AUTO_ACTIVE       // Automatic pattern is overriding
);

////////////////////////////////////////////////////////////////////////////////
// Defect synchronisers

    // Defects come from the receive domain; two flops keep metastability out
    esa_defect_t meta_q;
    esa_defect_t sync_q;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= '{SIGNAL_LOSS, FRAME_LOSS, POWER_LOSS};
            sync_q <= meta_q;
        end
    end

    logic line_loss;
    assign line_loss = sync_q.signal_loss | sync_q.frame_loss;

////////////////////////////////////////////////////////////////////////////////
// APB register slave

    logic [7:0] ctrl_q;
    logic       hit_ctrl;
    logic       hit_stat;
    logic       apb_acc;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
        addr_is = (a[11:2] == ref_a[11:2]);
    endfunction

    // Byte lanes within a word are ignored, so any address inside the word hits it
    assign hit_ctrl = addr_is(PADDR, `ESA_CTRL1_ADDR);
    assign hit_stat = addr_is(PADDR, `ESA_STATUS_ADDR);
    assign apb_acc  = PSEL & PENABLE;
    // Zero wait states: every transfer ends in its first access cycle
    assign PREADY   = 1'b1;
    assign PSLVERR  = apb_acc & ~(hit_ctrl | hit_stat);

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ctrl_q <= `ESA_CTRL1_RESET;
        else if (apb_acc && PWRITE && hit_ctrl)
            ctrl_q <= PWDATA[7:0];
    end

    esa_sel_t sel_q;

    // Read data is captured in the setup cycle, so it already stands when the
    // zero-wait access phase completes; writes to the status word are dropped

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            if (hit_ctrl)
                PRDATA <= {24'h00_0000, ctrl_q};
            else if (hit_stat)
                PRDATA <= {25'h000_0000, sync_q, sel_q};
            else
                PRDATA <= 32'h0000_0000;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Pattern selection, highest enabled bit first

    esa_sel_t sel_d;
    esa_sel_t sel_now;

    // A new choice applies from the strobe that starts a submultiframe
    assign sel_now = (FRAME_STROBE && SMF_START) ? sel_d : sel_q;

    // Enables 2 and 1 act even where software treats them as reserved
    always_comb
    begin
        sel_d = ESA_SEL_NONE;                                              // [RQ9]
        if (ctrl_q[`ESA_BIT_CL1] && line_loss)
            sel_d = ESA_SEL_CL1;                                           // [RQ10]
        else if (ctrl_q[`ESA_BIT_SL1] && sync_q.signal_loss)
            sel_d = ESA_SEL_SL1;
        else if (ctrl_q[`ESA_BIT_CL2] && line_loss)
            sel_d = ESA_SEL_CL2;
        else if (ctrl_q[`ESA_BIT_CL3] && line_loss)
            sel_d = ESA_SEL_CL3;
        else if (ctrl_q[`ESA_BIT_CL4] && line_loss)
            sel_d = ESA_SEL_CL4;
        else if (ctrl_q[`ESA_BIT_PWR] && sync_q.power_loss)
            sel_d = ESA_SEL_PWR;
        else if (ctrl_q[`ESA_BIT_PWRLINE] && sync_q.power_loss && line_loss)
            sel_d = ESA_SEL_PWRLINE;
        else if (ctrl_q[`ESA_BIT_SLAUX] && sync_q.signal_loss)
            sel_d = ESA_SEL_SLAUX;
    end

    // Selection changes only at a submultiframe start so a nibble is never split
    // A defect that clears mid-submultiframe keeps its pattern until the next start
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            sel_q <= ESA_SEL_NONE;
        else if (FRAME_STROBE && SMF_START)
            sel_q <= sel_d;                                                // [RQ9]
    end

////////////////////////////////////////////////////////////////////////////////
// Bit position within the submultiframe

    // Position of the next strobe; a missing start strobe lets it wrap freely
    logic [2:0] pos_q;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            pos_q <= 3'h0;
        else if (FRAME_STROBE)
            pos_q <= SMF_START ? 3'h1 : pos_q + 3'h1;
    end

    logic [1:0] nib_idx;
    logic [2:0] aux_idx;
    assign nib_idx = SMF_START ? 2'h0 : pos_q[1:0];
    assign aux_idx = SMF_START ? 3'h0 : pos_q;

    function automatic logic nib_bit(input logic [3:0] pat, input logic [1:0] idx);
        nib_bit = pat[2'h3 - idx];                                         // [RQ10]
    endfunction

    esa_ovh_t ovh_d;
    logic     aux_bit;
    // The auxiliary pattern spans all eight frames, so it uses the full position
    assign aux_bit = 1'(`ESA_AUX_PATTERN >> (3'h7 - aux_idx));            // [RQ6]

    always_comb
    begin
        ovh_d = NORMAL_OVH;
        unique case (sel_now)
            ESA_SEL_NONE:
                ovh_d = NORMAL_OVH;                                        // [RQ9]
            ESA_SEL_CL1:
                ovh_d = '{NORMAL_OVH.a_bit, 1'b1, nib_bit(`ESA_SA6_ZERO, nib_idx)}; // [RQ1]
            ESA_SEL_SL1:
                ovh_d = '{1'b1, 1'b1, nib_bit(`ESA_SA6_1110, nib_idx)};   // [RQ2]
            ESA_SEL_CL2:
                ovh_d = '{1'b1, 1'b0, nib_bit(`ESA_SA6_ZERO, nib_idx)};   // [RQ3]
            ESA_SEL_CL3:
                ovh_d = '{1'b0, 1'b1, nib_bit(`ESA_SA6_1100, nib_idx)};   // [RQ4]
            ESA_SEL_CL4:
                ovh_d = '{1'b0, 1'b1, nib_bit(`ESA_SA6_1110, nib_idx)};   // [RQ5]
            // Sa5 for this pattern is unknown and is sent as zero
            ESA_SEL_PWR:
                ovh_d = '{1'b0, `ESA_PWR_SA5, nib_bit(`ESA_SA6_1000, nib_idx)}; // [RQ7]
            ESA_SEL_PWRLINE:
                ovh_d = '{1'b1, 1'b0, nib_bit(`ESA_SA6_1000, nib_idx)};   // [RQ8]
            ESA_SEL_SLAUX:
                ovh_d = '{NORMAL_OVH.a_bit, aux_bit, aux_bit};             // [RQ6]
            default:
                ovh_d = NORMAL_OVH;
        endcase
    end

    // Overhead bits are registered per frame so the framer sees a stable value
    // Between strobes the outputs stand, so the framer may sample them any time
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            TX_OVH      <= '0;
            AUTO_ACTIVE <= 1'b0;
        end
        else if (FRAME_STROBE)
        begin
            TX_OVH      <= ovh_d;
            AUTO_ACTIVE <= sel_now != ESA_SEL_NONE;
        end
    end

endmodule

// ===== tb/esa_sva.sv
`timescale 1ns/10ps
module esa_sva
    import esa_pkg::*;
(
    input logic        SYS_CLK,      // Clock
    input logic        RST_N,        // Reset
    input logic        PSEL,         // Select
    input logic        PENABLE,      // Access
    input logic        PWRITE,       // Write
    input logic [11:0] PADDR,        // Address
    input logic [31:0] PWDATA,       // Data
    input logic        PREADY,       // Ready
    input logic        PSLVERR,      // Error
    input logic        SIGNAL_LOSS,  // Signal loss
    input logic        FRAME_STROBE, // Frame
    input logic        SMF_START,    // Frame 0
    input esa_ovh_t    NORMAL_OVH,   // Normal bits
    input esa_ovh_t    TX_OVH,       // Sent bits
    input logic        AUTO_ACTIVE   // Override
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (!RST_N);
logic [7:0] ctrl_q;
wire        acc = PSEL && PENABLE;
wire        map = PADDR == 12'h4c4 || PADDR == 12'h4c8;
// Shadow of the enables, so a pattern can be tied to its cause
always_ff @(posedge SYS_CLK or negedge RST_N)
    if (!RST_N)
        ctrl_q <= 8'h00;
    else if (acc && PWRITE && PADDR == 12'h4c4)
        ctrl_q <= PWDATA[7:0];
ready_high_a: assert property (PREADY) else $error("ready low");
bad_addr_a: assert property (acc && !map |-> PSLVERR) else $error("no error");
good_addr_a: assert property (acc && map |-> !PSLVERR) else $error("false error");
idle_err_a: assert property (!acc |-> !PSLVERR) else $error("idle error");
ovh_hold_a: assert property (!FRAME_STROBE |=> $stable(TX_OVH))
    else $error("bits moved");
sel_hold_a: assert property (!(FRAME_STROBE && SMF_START) |=> $stable(AUTO_ACTIVE))
    else $error("override moved");
pass_thru_a: assert property (FRAME_STROBE && !SMF_START && !AUTO_ACTIVE
    |=> TX_OVH == $past(NORMAL_OVH)) else $error("normal bits lost");
los_pat_a: assert property (FRAME_STROBE && SMF_START && ctrl_q[7:6] == 2'b01
    && SIGNAL_LOSS && $past(SIGNAL_LOSS) && $past(SIGNAL_LOSS, 2)
    |=> TX_OVH == 3'b111 && AUTO_ACTIVE) else $error("loss pattern missing");
endmodule

// ===== tb/esa_framer_model.sv
`timescale 1ns/10ps
module esa_framer_model
(
    input  logic clk,   // Clock
    input  logic rst_n, // Reset
    output logic stb,   // Frame strobe
    output logic smf    // Frame 0 of eight
);
logic [1:0] gap_q;
logic [2:0] idx_q;
// Strobes four cycles apart leave room to sample each result
assign stb = gap_q == 2'h3;
assign smf = stb && idx_q == 3'h0;
always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
        gap_q <= 2'h0;
    else
        gap_q <= gap_q + 2'h1;
always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
        idx_q <= 3'h0;
    else if (stb)
        idx_q <= idx_q + 3'h1;
endmodule

// ===== tb/test_e1_auto_sa_alarm_insert.sv
`timescale 1ns/10ps
module test_e1_auto_sa_alarm_insert;
import esa_pkg::*;
logic        clk, rst_n, psel, pen, pwr, los, lfa, pwl, stb, smf, prdy, perr, act, er;
logic [11:0] pa;
logic [31:0] pwd, prd, rd;
logic [2:0]  n;
esa_ovh_t    nrm, tx;
int          mismatches, n_compared, seed, c;
esa_auto_alarm dut(.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SIGNAL_LOSS(los),
    .FRAME_LOSS(lfa), .POWER_LOSS(pwl), .FRAME_STROBE(stb), .SMF_START(smf),
    .NORMAL_OVH(nrm), .TX_OVH(tx), .AUTO_ACTIVE(act));
esa_framer_model frm(.clk(clk), .rst_n(rst_n), .stb(stb), .smf(smf));
initial
begin
    clk = 0;
    forever #5 clk = ~clk;
end
always @(posedge clk) nrm <= 3'($random(seed));
task chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
endtask
task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
endtask
// Expected {active, A, Sa5, Sa6}; highest enable wins
function logic [3:0] expv(logic [7:0] c, logic l, f, p, int k, logic [2:0] n);
    logic lf;
    int   m;
    lf = l | f;
    m = k % 4;
    if (c[7] && lf) return {1'b1, n[2], 2'b10};
    if (c[6] && l) return {3'b111, m != 3};
    if (c[5] && lf) return 4'hc;
    if (c[4] && lf) return {3'b101, m < 2};
    if (c[3] && lf) return {3'b101, m != 3};
    if (c[2] && p) return {3'b100, m == 0};
    if (c[1] && p && lf) return {3'b110, m == 0};
    if (c[0] && l) return {1'b1, n[2], k % 2 == 0, k % 2 == 0};
    return {1'b0, n};
endfunction
// Expected status selection code: 1 for bit 7 down to 8 for bit 0, 0 for none
function logic [3:0] sel_code(logic [7:0] c, logic l, f, p);
    logic [7:0] hit;
    hit = c & {l | f, l, l | f, l | f, l | f, p, p & (l | f), l};
    for (int b = 7; b >= 0; b--)
        if (hit[b])
            return 4'(8 - b);
    return 4'h0;
endfunction
task stop_test;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
initial
begin
    #100000;
    mismatches++;
    stop_test;
end
initial
begin
    {seed, mismatches, n_compared} = {32'd12, 64'd0};
    {rst_n, psel, pen, pwr, pa, pwd, los, lfa, pwl} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    apb(0, 12'h4c4, 0);
    chk("ctrl reset", 0, rd);
    apb(1, 12'h4cc, 32'hff);
    chk("unmapped err", 1, er);
    apb(0, 12'h4cc, 0);
    chk("unmapped read", 0, rd);
    for (int i = 0; i < 24; i++)
    begin
        c = i < 8 ? 1 << i : $random(seed);
        apb(1, 12'h4c4, 32'hffffff00 | c);
        apb(0, 12'h4c4, 0);
        chk("ctrl", c & 255, rd);
        {los, lfa, pwl} <= i < 8 ? 3'h7 : 3'($random(seed));
        // The first boundary may still see the old defects
        repeat (2) do @(negedge clk); while (!(stb && smf));
        for (int k = 0; k < 8; k++)
        begin
            if (k > 0) do @(negedge clk); while (!stb);
            n = nrm;
            @(negedge clk);
            chk("frame", expv(c[7:0], los, lfa, pwl, k, n), {act, tx});
        end
        apb(0, 12'h4c8, 0);
        chk("status", {los, lfa, pwl, sel_code(c[7:0], los, lfa, pwl)}, rd);
        $display("test %0d done", i);
    end
    // A reset in mid-run must drop any override and clear the enables
    rst_n <= 0;
    @(negedge clk);
    chk("reset bits", 0, {act, tx});
    repeat (3) @(posedge clk);
    rst_n <= 1;
    apb(0, 12'h4c4, 0);
    chk("ctrl after reset", 0, rd);
    stop_test;
end
endmodule
bind esa_auto_alarm esa_sva sva_i(.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SIGNAL_LOSS(SIGNAL_LOSS), .FRAME_STROBE(FRAME_STROBE),
    .SMF_START(SMF_START), .NORMAL_OVH(NORMAL_OVH), .TX_OVH(TX_OVH), .AUTO_ACTIVE(AUTO_ACTIVE));
